// [design/rsq_top.sv]
`timescale 1ns/100ps
`include "rsq_cfg.svh"
// Summary of operation
// R1 - five reset sources are told apart: power-on, pin clear running or asleep, watchdog running or asleep.
// R2 - a wake from sleep by pin clear or watchdog is a full reset, the core never resumes.
// R3 - registers without a reset value start unknown and keep their contents on any later reset.
// R4 - status bits 4:3 take 11 on power-on, stay on pin clear running, 10 on pin wake, 01 on watchdog, 00 on watchdog wake.
// R5 - status page bits clear on every reset; arithmetic bits are kept except on power-on.
// R6 - direction, low program counter and prescaler options go to all ones on every reset.
// R7 - the pointer gets its top three bits set on small parts and its top bit on large parts.
// R8 - power-on sets the reset latch and clears the reset timer before code runs.
// R9 - the reset timer starts once pin clear is seen high and releases reset when it expires.
// R10 - the reset timer steps on the internal oscillator tick, not on the main clock mode.
// R11 - the core stays in reset while the reset timer runs.
// R12 - every watchdog time-out restarts the reset timer and holds reset until it expires again.
// R13 - only a supply rise raises power-on reset; a falling supply does nothing.
// R14 - the outside network should pull pin clear low on a brown-out.
// R15 - the outside network keeps pin clear low until operating conditions are valid.
// R16 - with pin clear raised late, reset ends one timer period after its rising edge.
// R17 - pin clear low holds the latch set and the timer clear; the pin goes through a synchroniser.
module rsq_top #(
    parameter int P_DRT_CYCLES = `RSQ_DRT_CYCLES
) (
    // clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_ce,
    // reset sources
    input  wire logic        i_supply_ok,
    input  wire logic        i_master_clear_n,
    input  wire logic        i_wdt_timeout,
    input  wire logic        i_sleeping,
    input  wire logic        i_rc_tick,
    // reset state towards the core
    output logic             o_core_reset,
    output logic [7:0]       o_status,
    output logic [7:0]       o_pcl,
    output logic [7:0]       o_fsr,
    output logic [7:0]       o_pin_direction_control,
    output logic [5:0]       o_option,
    output logic             o_irq,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp
);
    // ---------------------------------------------------------------
    // pin synchroniser and edge detection
    // ---------------------------------------------------------------
    logic master_clear_n_meta_reg;
    logic master_clear_n_sync_reg;
    logic master_clear_n_prev_reg;
    logic supply_prev_reg;

    // meta stage feeds the sync stage only
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            master_clear_n_meta_reg   <= 1'b1;
            master_clear_n_sync_reg   <= 1'b1;
            master_clear_n_prev_reg   <= 1'b1;
            supply_prev_reg <= 1'b0;
        end else if (i_ce) begin
            master_clear_n_meta_reg   <= i_master_clear_n; // see R17
            master_clear_n_sync_reg   <= master_clear_n_meta_reg;
            master_clear_n_prev_reg   <= master_clear_n_sync_reg;
            supply_prev_reg <= i_supply_ok;
        end
    end

    // cause decode; power-on first, then pin, then watchdog
    wire                 por_evt  = i_supply_ok && !supply_prev_reg; // see R13
    wire                 master_clear_n_evt = master_clear_n_prev_reg && !master_clear_n_sync_reg;
    wire                 wdt_evt  = i_wdt_timeout;
    rsq_pkg::rsq_cause_t cause;
    assign cause = por_evt  ? rsq_pkg::RSQ_C_POR :
                   master_clear_n_evt ? (i_sleeping ? rsq_pkg::RSQ_C_MASTER_CLEAR_N_WAKE : rsq_pkg::RSQ_C_MASTER_CLEAR_N_RUN) :
                   wdt_evt  ? (i_sleeping ? rsq_pkg::RSQ_C_WDT_WAKE : rsq_pkg::RSQ_C_WDT_RUN) :
                   rsq_pkg::RSQ_C_NONE; // see R1
    wire any_evt = (cause != rsq_pkg::RSQ_C_NONE);

    // timeout and powerdown flags per cause
    function automatic logic [1:0] cause_flags(rsq_pkg::rsq_cause_t c, logic [1:0] old);
        case (c)
            rsq_pkg::RSQ_C_POR:       cause_flags = 2'b11;
            rsq_pkg::RSQ_C_MASTER_CLEAR_N_RUN:  cause_flags = old;
            rsq_pkg::RSQ_C_MASTER_CLEAR_N_WAKE: cause_flags = 2'b10;
            rsq_pkg::RSQ_C_WDT_RUN:   cause_flags = 2'b01;
            rsq_pkg::RSQ_C_WDT_WAKE:  cause_flags = 2'b00;
            default:                  cause_flags = old;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // reset sequencer; the state itself is the reset latch
    // ---------------------------------------------------------------
    rsq_pkg::rsq_state_t state_reg;
    rsq_pkg::rsq_state_t state_next;
    logic                core_reset_reg;
    rsq_drt_if           drt_if ();

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rsq_pkg::RSQ_S_RUN: begin
                if (any_evt || !master_clear_n_sync_reg)
                    state_next = rsq_pkg::RSQ_S_HOLD; // see R2
            end
            rsq_pkg::RSQ_S_HOLD: begin
                // waits for the pin, whoever holds it low
                if (!any_evt && master_clear_n_sync_reg)
                    state_next = rsq_pkg::RSQ_S_TIME; // see R9
            end
            rsq_pkg::RSQ_S_TIME: begin
                if (any_evt || !master_clear_n_sync_reg)
                    state_next = rsq_pkg::RSQ_S_HOLD; // see R12
                else if (drt_if.done)
                    state_next = rsq_pkg::RSQ_S_RUN; // see R16
            end
            default: state_next = rsq_pkg::RSQ_S_HOLD;
        endcase
    end

    // timer is cleared in every state but timing
    // a new cause clears the count at once, even while timing
    assign drt_if.clear    = (state_reg != rsq_pkg::RSQ_S_TIME) || any_evt ||
                             !master_clear_n_sync_reg; // see R8 R12 R17
    assign drt_if.count_en = (state_reg == rsq_pkg::RSQ_S_TIME);
    assign drt_if.tick     = i_rc_tick; // see R10

    rsq_drt #(
        .P_TICKS (P_DRT_CYCLES)
    ) u_drt (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_ce     (i_ce),
        .t        (drt_if)
    );

    // bus reset acts as power-up: latch set, timer clear
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_reg      <= rsq_pkg::RSQ_S_HOLD; // see R8
            core_reset_reg <= 1'b1;
        end else if (i_ce) begin
            state_reg      <= state_next;
            core_reset_reg <= (state_next != rsq_pkg::RSQ_S_RUN); // see R11
        end
    end

    // ---------------------------------------------------------------
    // bus slave: zero wait states, always okay
    // ---------------------------------------------------------------
    wire       ahb_take = i_hsel && i_htrans[1] && i_hready;
    wire [3:0] a_idx    = i_haddr[5:2];
    wire       a_mapped = (i_haddr[31:6] == 26'h0) && (a_idx <= `RSQ_IDX_INT_CLR);
    logic       wr_pend_reg;
    logic [3:0] wr_idx_reg;
    logic [31:0] hrdata_reg;

    // data-phase write strobes
    wire wr_status = wr_pend_reg && (wr_idx_reg == `RSQ_IDX_STATUS);
    wire wr_pcl    = wr_pend_reg && (wr_idx_reg == `RSQ_IDX_PCL);
    wire wr_fsr    = wr_pend_reg && (wr_idx_reg == `RSQ_IDX_FSR);
    wire wr_pin_direction_control   = wr_pend_reg && (wr_idx_reg == `RSQ_IDX_PIN_DIRECTION_CONTROL);
    wire wr_option = wr_pend_reg && (wr_idx_reg == `RSQ_IDX_OPTION);
    wire wr_ctrl   = wr_pend_reg && (wr_idx_reg == `RSQ_IDX_CTRL);
    wire wr_int_en = wr_pend_reg && (wr_idx_reg == `RSQ_IDX_INT_EN);
    wire wr_int_cl = wr_pend_reg && (wr_idx_reg == `RSQ_IDX_INT_CLR);
    wire wr_keep   = wr_pend_reg && ((wr_idx_reg == `RSQ_IDX_TMR) ||
                     (wr_idx_reg == `RSQ_IDX_W) ||
                     (wr_idx_reg >= `RSQ_IDX_PORT_A_PINS && wr_idx_reg <= `RSQ_IDX_PORT_C_PINS));
    // the pointer window is not physical, so slot 0 holds the accumulator
    wire [2:0] keep_slot = (wr_idx_reg == `RSQ_IDX_W) ? 3'h0 : wr_idx_reg[2:0];

    // ---------------------------------------------------------------
    // architectural registers with reset values
    // ---------------------------------------------------------------
    logic [7:0] status_reg;
    logic [7:0] pcl_reg;
    logic [7:0] fsr_reg;
    logic [7:0] pin_direction_control_reg;
    logic [5:0] option_reg;
    logic       large_reg;
    logic [7:0] keep_mem [0:7];

    // reset event beats a software write in the same cycle
    wire [7:0] status_next = (cause == rsq_pkg::RSQ_C_POR) ? `RSQ_STATUS_POR :
        any_evt   ? {`RSQ_PAGE_RST, cause_flags(cause, status_reg[4:3]), status_reg[2:0]} :
        wr_status ? {i_hwdata[7:5], status_reg[4:3], i_hwdata[2:0]} : status_reg; // see R4
    wire [7:0] fsr_set  = large_reg ? `RSQ_FSR_SET_LARGE : `RSQ_FSR_SET_SMALL;
    wire [7:0] fsr_next = any_evt ? (fsr_reg | fsr_set) :
                          wr_fsr  ? i_hwdata[7:0] : fsr_reg; // see R7

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            status_reg <= `RSQ_STATUS_POR; // see R5
            pcl_reg    <= `RSQ_PCL_RST;
            fsr_reg    <= `RSQ_FSR_SET_SMALL;
            pin_direction_control_reg   <= `RSQ_PIN_DIRECTION_CONTROL_RST;
            option_reg <= `RSQ_OPTION_RST;
            large_reg  <= 1'b0;
        end else if (i_ce) begin
            status_reg <= status_next; // see R5
            fsr_reg    <= fsr_next;
            pcl_reg    <= any_evt ? `RSQ_PCL_RST : (wr_pcl ? i_hwdata[7:0] : pcl_reg); // see R6
            pin_direction_control_reg   <= any_evt ? `RSQ_PIN_DIRECTION_CONTROL_RST : (wr_pin_direction_control ? i_hwdata[7:0] : pin_direction_control_reg);
            option_reg <= any_evt ? `RSQ_OPTION_RST : (wr_option ? i_hwdata[5:0] : option_reg);
            large_reg  <= wr_ctrl ? i_hwdata[0] : large_reg;
        end
    end

    // no reset on purpose: contents survive every reset
    always_ff @(posedge i_clk) begin
        if (i_ce && wr_keep)
            keep_mem[keep_slot] <= i_hwdata[7:0]; // see R3
    end

    // ---------------------------------------------------------------
    // reset-cause interrupts
    // ---------------------------------------------------------------
    logic [`RSQ_INT_W-1:0] int_sts_reg;
    logic [`RSQ_INT_W-1:0] int_en_reg;
    logic                  irq_reg;
    wire                   rel_evt = (state_reg == rsq_pkg::RSQ_S_TIME) &&
                                     (state_next == rsq_pkg::RSQ_S_RUN);
    wire [`RSQ_INT_W-1:0]  int_set = {rel_evt, cause};
    wire [`RSQ_INT_W-1:0]  int_clr = wr_int_cl ? i_hwdata[`RSQ_INT_W-1:0] : '0;
    // a new event wins over a clear in the same cycle
    wire [`RSQ_INT_W-1:0]  int_sts_next = (int_sts_reg & ~int_clr) | int_set;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            int_sts_reg <= '0;
            int_en_reg  <= '0;
            irq_reg     <= 1'b0;
        end else if (i_ce) begin
            int_sts_reg <= int_sts_next;
            int_en_reg  <= wr_int_en ? i_hwdata[`RSQ_INT_W-1:0] : int_en_reg;
            irq_reg     <= |(int_sts_reg & int_en_reg);
        end
    end

    // ---------------------------------------------------------------
    // read path, sampled in the address phase
    // ---------------------------------------------------------------
    function automatic logic [7:0] reg_read(logic [3:0] idx);
        case (idx)
            `RSQ_IDX_TMR, `RSQ_IDX_PORT_B_PINS, `RSQ_IDX_PORT_C_PINS: reg_read = keep_mem[idx[2:0]];
            `RSQ_IDX_PORT_A_PINS:   reg_read = {4'h0, keep_mem[5][3:0]};
            `RSQ_IDX_W:       reg_read = keep_mem[0];
            `RSQ_IDX_PCL:     reg_read = pcl_reg;
            `RSQ_IDX_STATUS:  reg_read = status_reg;
            `RSQ_IDX_FSR:     reg_read = fsr_reg;
            `RSQ_IDX_CTRL:    reg_read = {5'h00, core_reset_reg,
                                          drt_if.busy, large_reg};
            `RSQ_IDX_INT_STS: reg_read = {2'h0, int_sts_reg};
            `RSQ_IDX_INT_EN:  reg_read = {2'h0, int_en_reg};
            default:          reg_read = 8'h00;
        endcase
    endfunction

    wire [7:0] rd_mux = a_mapped ? reg_read(a_idx) : 8'h00;

    // single-word transfers only; narrower sizes act as a word
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 4'h0;
            hrdata_reg  <= 32'h0;
        end else if (i_ce) begin
            wr_pend_reg <= ahb_take && i_hwrite && a_mapped;
            wr_idx_reg  <= a_idx;
            hrdata_reg  <= (ahb_take && !i_hwrite) ? {24'h0, rd_mux} : 32'h0;
        end
    end

    // outputs straight from flops
    assign o_core_reset = core_reset_reg;
    assign o_status     = status_reg;
    assign o_pcl        = pcl_reg;
    assign o_fsr        = fsr_reg;
    assign o_pin_direction_control       = pin_direction_control_reg;
    assign o_option     = option_reg;
    assign o_irq        = irq_reg;
    assign o_hrdata     = hrdata_reg;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    property p_por_latch;
        i_ce && por_evt |=> core_reset_reg && !drt_if.busy;
    endproperty
    a_por_latch: assert property (p_por_latch) else $error("power-on did not set latch"); // see R8

    property p_master_clear_n_wake;
        i_ce && !por_evt && master_clear_n_evt && i_sleeping |=> status_reg[4:3] == 2'b10;
    endproperty
    a_master_clear_n_wake: assert property (p_master_clear_n_wake) else $error("pin wake flags wrong"); // see R4

    property p_master_clear_n_run;
        i_ce && !por_evt && master_clear_n_evt && !i_sleeping |=> status_reg[4:3] == $past(status_reg[4:3]);
    endproperty
    a_master_clear_n_run: assert property (p_master_clear_n_run) else $error("pin reset changed flags"); // see R4

    property p_wdt_flags;
        i_ce && !por_evt && !master_clear_n_evt && wdt_evt
            |=> status_reg[4:3] == ($past(i_sleeping) ? 2'b00 : 2'b01);
    endproperty
    a_wdt_flags: assert property (p_wdt_flags) else $error("watchdog flags wrong"); // see R4

    property p_page_clear;
        i_ce && any_evt |=> status_reg[7:5] == 3'h0 && pcl_reg == 8'hff
            && pin_direction_control_reg == 8'hff && option_reg == 6'h3f;
    endproperty
    a_page_clear: assert property (p_page_clear) else $error("reset values not loaded"); // see R6

    property p_fsr_top;
        i_ce && any_evt |=> (large_reg ? fsr_reg[7] : fsr_reg[7:5] == 3'b111);
    endproperty
    a_fsr_top: assert property (p_fsr_top) else $error("pointer top bits not set"); // see R7

    property p_hold_low;
        i_ce && !master_clear_n_sync_reg |=> core_reset_reg ##1 (!i_ce || core_reset_reg);
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("reset dropped with pin low"); // see R17

    property p_release;
        i_ce && state_reg == rsq_pkg::RSQ_S_TIME && drt_if.done && !any_evt && master_clear_n_sync_reg
            |=> !core_reset_reg;
    endproperty
    a_release: assert property (p_release) else $error("no release at timer expiry"); // see R9

    property p_no_early;
        i_ce && core_reset_reg && !drt_if.done |=> core_reset_reg;
    endproperty
    a_no_early: assert property (p_no_early) else $error("reset left before expiry"); // see R11

    property p_wdt_restart;
        i_ce && wdt_evt |=> core_reset_reg ##1 (!i_ce || !drt_if.busy);
    endproperty
    a_wdt_restart: assert property (p_wdt_restart) else $error("watchdog kept timer"); // see R12

    property p_fall_quiet;
        i_ce && !core_reset_reg && master_clear_n_sync_reg && !master_clear_n_meta_reg == 1'b0 && !wdt_evt
            && !i_supply_ok && !por_evt |=> !core_reset_reg;
    endproperty
    a_fall_quiet: assert property (p_fall_quiet) else $error("supply fall raised reset"); // see R13

    c_release:   cover property (rel_evt);
    c_wdt_wake:  cover property (cause == rsq_pkg::RSQ_C_WDT_WAKE);
    c_master_clear_n_wake: cover property (cause == rsq_pkg::RSQ_C_MASTER_CLEAR_N_WAKE);
    c_irq:       cover property (irq_reg);
endmodule // rsq_top

// [design/rsq_cfg.svh]
`ifndef RSQ_CFG_SVH
`define RSQ_CFG_SVH

// register indexes; byte address is four times the index
`define RSQ_IDX_INDIRECT_DATA_WINDOW      4'h0
`define RSQ_IDX_TMR       4'h1
`define RSQ_IDX_PCL       4'h2
`define RSQ_IDX_STATUS    4'h3
`define RSQ_IDX_FSR       4'h4
`define RSQ_IDX_PORT_A_PINS     4'h5
`define RSQ_IDX_PORT_B_PINS     4'h6
`define RSQ_IDX_PORT_C_PINS     4'h7
`define RSQ_IDX_PIN_DIRECTION_CONTROL      4'h8
`define RSQ_IDX_OPTION    4'h9
`define RSQ_IDX_W         4'ha
`define RSQ_IDX_CTRL      4'hb
`define RSQ_IDX_INT_STS   4'hc
`define RSQ_IDX_INT_EN    4'hd
`define RSQ_IDX_INT_CLR   4'he

// status field positions and reset values
`define RSQ_ST_TO         4
`define RSQ_ST_PD         3
`define RSQ_STATUS_POR    8'h18
`define RSQ_PAGE_RST      3'h0
`define RSQ_PCL_RST       8'hff
`define RSQ_PIN_DIRECTION_CONTROL_RST      8'hff
`define RSQ_OPTION_RST    6'h3f
`define RSQ_FSR_SET_SMALL 8'he0
`define RSQ_FSR_SET_LARGE 8'h80
`define RSQ_INT_W         6

// reset timer
`define RSQ_CLK_PERIOD_NS 40
`define RSQ_DRT_TIME_MS   18
`define RSQ_DRT_CYCLES    ((`RSQ_DRT_TIME_MS * 1000000) / `RSQ_CLK_PERIOD_NS)

`endif

// [design/rsq_pkg.sv]
package rsq_pkg;

    // sequencer states; anything but run holds the core in reset
    typedef enum logic [2:0] {
        RSQ_S_RUN  = 3'b001,
        RSQ_S_HOLD = 3'b010,
        RSQ_S_TIME = 3'b100
    } rsq_state_t;

    // reset cause, one bit each, in interrupt status order
    typedef enum logic [4:0] {
        RSQ_C_NONE      = 5'b00000,
        RSQ_C_POR       = 5'b00001,
        RSQ_C_MASTER_CLEAR_N_RUN  = 5'b00010,
        RSQ_C_MASTER_CLEAR_N_WAKE = 5'b00100,
        RSQ_C_WDT_RUN   = 5'b01000,
        RSQ_C_WDT_WAKE  = 5'b10000
    } rsq_cause_t;

endpackage

// [design/rsq_drt_if.sv]
`timescale 1ns/100ps
// link between the sequencer and the device reset timer
interface rsq_drt_if;
    logic clear;
    logic count_en;
    logic tick;
    logic done;
    logic busy;

    modport seq (output clear, output count_en, output tick, input done, input busy);
    modport tmr (input clear, input count_en, input tick, output done, output busy);
endinterface

// [design/rsq_drt.sv]
`timescale 1ns/100ps
`include "rsq_cfg.svh"

module rsq_drt #(
    parameter int P_TICKS = `RSQ_DRT_CYCLES
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_ce,
    // sequencer side
    rsq_drt_if.tmr    t
);
    localparam int W = $clog2(P_TICKS + 1);

    // a period below two ticks leaves no room for the done pulse
    generate
        if (P_TICKS < 2) begin : g_bad_ticks
            $error("rsq_drt: P_TICKS must be at least 2");
        end
    endgenerate

    logic [W-1:0] cnt_reg;
    logic         done_reg;

    wire          step    = t.count_en && t.tick;
    wire          at_last = (cnt_reg == W'(P_TICKS - 1));

    assign t.done = done_reg;
    assign t.busy = (cnt_reg != '0);

    // counts only on oscillator ticks, cleared while held
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else if (i_ce) begin
            if (t.clear)
                cnt_reg <= '0;
            else if (step)
                cnt_reg <= at_last ? '0 : cnt_reg + 1'b1;
            done_reg <= !t.clear && step && at_last;
        end
    end
endmodule // rsq_drt

// [sim/rsq_reset_net.sv]
`timescale 1ns/100ps
// outside supervisor on the clear pin and the supply
module rsq_reset_net (
    // clock
    input  wire logic i_clk,
    // lines towards the device
    output logic      o_supply_ok,
    output logic      o_master_clear_n
);
    // supply good and pin released from the start
    initial begin
        o_supply_ok = 1'b1;
        o_master_clear_n = 1'b1;
    end
    // pin low for n cycles
    task automatic pulse(input int n);
        @(posedge i_clk) o_master_clear_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_master_clear_n <= 1'b1;
    endtask
    // supply dip; with_pin=0 is a faulty supervisor that ignores it
    task automatic dip(input int with_pin, input int n);
        @(posedge i_clk) o_supply_ok <= 1'b0;
        if (with_pin != 0) o_master_clear_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_supply_ok <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_master_clear_n <= 1'b1;
    endtask
endmodule // rsq_reset_net

// [sim/test_reset_sequencer_with_cause_flags.sv]
`timescale 1ns/100ps
module test_reset_sequencer_with_cause_flags;
    localparam int P = 20;
    // stimulus and observed lines
    logic        clk = 1'b0, rstn = 1'b0, slp = 1'b0, wdt = 1'b0;
    logic        hwrite = 1'b0, rd_ph = 1'b0;
    logic [1:0]  htrans = 2'h0, tp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic        sup, mcn, core_rst, irq, hready, hresp;
    logic [7:0]  pin_direction_control_o;
    logic [5:0]  opt_o;
    logic [31:0] expq[$];
    logic [31:0] ev [6];
    logic [3:0]  widx [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9};
    logic [3:0]  ridx [6] = '{4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hf};
    int          n_fail = 0, tests_run = 0, cyc = 0, seed = 36;

    always #20 clk = ~clk;

    rsq_reset_net net (.i_clk(clk), .o_supply_ok(sup), .o_master_clear_n(mcn));

    rsq_top #(.P_DRT_CYCLES(P)) dut (.i_clk(clk), .i_resetn(rstn), .i_ce(1'b1),
        .i_supply_ok(sup), .i_master_clear_n(mcn), .i_wdt_timeout(wdt), .i_sleeping(slp),
        .i_rc_tick(1'b1), .o_core_reset(core_rst), .o_status(), .o_pcl(), .o_fsr(),
        .o_pin_direction_control(pin_direction_control_o), .o_option(opt_o), .o_irq(irq), .i_hsel(1'b1), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict;
        if (n_fail == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // one word transfer; d is write data or, for a read, the expected value
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {26'h0, idx, 2'h0};
        hwrite <= wr;
        if (!wr) expq.push_back(d);
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
    endtask

    // bounded wait for the core to leave reset, k counts the held cycles
    task automatic wait_rel(input int lo);
        int k;
        k = 0;
        while (core_rst !== 1'b0 && k < 4 * P) begin
            @(posedge clk);
            k++;
        end
        check("release", k >= lo && k < 4 * P, 1);
    endtask

    // read data judged at the edge closing its data phase
    always @(posedge clk) begin
        if (rd_ph) begin
            check("hrdata", hrdata, expq.pop_front());
            check("hresp", hresp, 0);
        end
        rd_ph <= htrans[1] && !hwrite && hready && rstn;
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            n_fail++;
            give_verdict;
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        wait_rel(P);
        // direction and prescaler registers are write-only: read as zero
        ev = '{32'hff, 32'h18, 32'he0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 6; i++) bus(0, ridx[i], ev[i]);
        check("pin_direction_control", pin_direction_control_o, 8'hff);
        check("option", opt_o, 6'h3f);
        bus(0, 4'hc, 32'h21);
        bus(1, 4'hd, 32'h1e);
        tp = 2'b11;
        // pin run, pin wake, watchdog run, watchdog wake
        for (int c = 0; c < 4; c++) begin
            r = $random(seed);
            bus(1, 4'he, 32'h1e);
            repeat (2) @(posedge clk);
            check("irq_masked", irq, 0);
            bus(1, 4'he, 32'h3f);
            for (int j = 0; j < 6; j++) bus(1, widx[j], r);
            slp <= c[0];
            if (c < 2) net.pulse(c ? 2 * P : 3);
            else begin
                @(posedge clk) wdt <= 1'b1;
                @(posedge clk) wdt <= 1'b0;
            end
            repeat (2) @(posedge clk);
            check("core_reset", core_rst, 1);
            check("irq", irq, 1);
            wait_rel(P - 3);
            slp <= 1'b0;
            if (c > 0) tp = {!c[1], !c[0]};
            ev = '{{24'h0, r[7:0]}, 32'hff, {24'h0, 3'h0, tp, r[2:0]},
                   {24'h0, r[7:0] | 8'he0}, 32'h0, 32'h0};
            for (int j = 0; j < 6; j++) bus(0, widx[j], ev[j]);
            check("pin_direction_control", pin_direction_control_o, 8'hff);
            check("option", opt_o, 6'h3f);
            bus(0, 4'hc, 32'h20 | (32'h2 << c));
        end
        // supply dips, first without the pin, then with it
        for (int b = 0; b < 2; b++) begin
            fork
                net.dip(b, 6);
            join_none
            repeat (4) @(posedge clk);
            if (b == 0) check("core_reset", core_rst, 0);
            wait fork;
            repeat (3) @(posedge clk);
            // supply-only rise starts timing earlier than a held pin
            wait_rel(b ? P - 3 : P - 8);
            bus(0, 4'h3, 32'h18);
        end
        give_verdict;
    end
endmodule // test_reset_sequencer_with_cause_flags
